// ===== core/emcs_pkg.sv
package emcs_pkg;

	// ***************************************************************
	// Geometry
	// ***************************************************************
	localparam int ADDR_W        = 24;             // Byte address width
	localparam int BASE_W        = 16;             // Base and mask cover bits 31..16
	localparam int MASK_LSB      = 16;             // Mask starts at address bit 16
	localparam int NUM_CS        = 3;              // Chip selects
	localparam int WAIT_W        = 4;              // Wait state counter width

	// ***************************************************************
	// Port size encodings
	// ***************************************************************
	localparam logic [1:0] PW_32_BAD = 2'h0;       // Invalid on this unit
	localparam logic [1:0] PW_8      = 2'h1;       // Upper lane only

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic [WAIT_W-1:0] WAIT_RESET = 4'hF; // Slowest setting at reset
	localparam logic [1:0]        ST_RESET   = 2'h0; // Idle

	// ***************************************************************
	// Carriers
	// ***************************************************************
	// One chip select configuration
	typedef struct packed {
		logic [BASE_W-1:0] base;                   // Address bits 31..16 of base
		logic [BASE_W-1:0] mask;                   // Bits excluded from compare
		logic [WAIT_W-1:0] wait_state_count;       // Extra cycles before latch
		logic              auto_acknowledge;       // Internal acknowledge
		logic [1:0]        port_width_setting;     // 01 = 8 bit, 1X = 16 bit
		logic              valid;                  // Chip select enabled
	} emcs_cfg_type;

	// Host access request
	typedef struct packed {
		logic              start;                  // One-cycle start pulse
		logic              write;                  // 1 = write
		logic [31:0]       addr;                   // Byte address
		logic              byte_access;            // 8-bit access
		logic [15:0]       wdata;                  // Write data
	} emcs_req_type;

	// Transfer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SETUP = 2'b01,
		ST_WAIT  = 2'b10,
		ST_LATCH = 2'b11
	} emcs_state_type;

endpackage : emcs_pkg

// ===== core/emcs_decode.sv
`timescale 1ns/1ps
// Address decoder for the three chip selects
module emcs_decode
	import emcs_pkg::*;
(
	// Configuration
	input  wire emcs_cfg_type       cfg_i [NUM_CS],
	input  wire logic               zero_valid_i,
	// Address
	input  wire logic [31:0]        addr_i,
	// Result
	output logic [NUM_CS-1:0]       hit_o
);

	// ***************************************************************
	// Masked compare
	// ***************************************************************
	function automatic logic match(input emcs_cfg_type c, input logic [31:0] a);
		logic [BASE_W-1:0] care;
		care = ~c.mask;
		return c.valid && (((a[31:MASK_LSB] ^ c.base) & care) == '0);
	endfunction : match

	// Select one hit; lower index wins on overlap
	always_comb begin
		hit_o = '0;
		if (!zero_valid_i) begin
			hit_o[0] = 1'b1;                       // Boot select catches all
		end else if (match(cfg_i[0], addr_i)) begin
			hit_o[0] = 1'b1;
		end else if (match(cfg_i[1], addr_i)) begin
			hit_o[1] = 1'b1;
		end else if (match(cfg_i[2], addr_i)) begin
			hit_o[2] = 1'b1;
		end
	end

endmodule : emcs_decode

// ===== core/emcs_top.sv
`timescale 1ns/1ps
module emcs_top
	import emcs_pkg::*;
(
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Configuration, one set per chip select
	input  wire emcs_cfg_type       cfg_i [NUM_CS],
	// Host request
	input  wire emcs_req_type       req_i,
	// Memory pins
	input  wire logic               transfer_acknowledge_n_i,
	input  wire logic [15:0]        mem_rdata_i,
	output logic [ADDR_W-1:0]       mem_addr_o,
	output logic [15:0]             mem_wdata_o,
	output logic                    mem_wdata_oe_o,
	output logic [NUM_CS-1:0]       cs_n_o,
	output logic                    oe_n_o,
	output logic                    rw_n_o,
	output logic [1:0]              byte_lane_select_n_o,
	// Host answer
	output logic                    busy_o,
	output logic                    done_o,
	output logic                    error_o,
	output logic [15:0]             rdata_o
);

	// ***************************************************************
	// State
	// ***************************************************************
	typedef struct packed {
		emcs_state_type    st;                     // Transfer phase
		logic [WAIT_W-1:0] cnt;                    // Wait states left
		logic              auto_ack;               // Latched for this cycle
		logic              wide;                   // 16-bit port
		logic              wr;                     // Write cycle
		logic              bytea;                  // Byte access
		logic              odd;                    // Address bit zero
		logic              zero_valid;             // Sticky until reset
		logic [1:0]        ack_sync;               // Pin synchroniser
		logic [ADDR_W-1:0] addr;
		logic [15:0]       wdata;
		logic              wdoe;
		logic [NUM_CS-1:0] cs_n;
		logic              oe_n;
		logic              rw_n;
		logic [1:0]        bls_n;
		logic              busy;
		logic              done;
		logic              err;
		logic [15:0]       rdata;
		logic [15:0]       rd_s1;                  // First sync stage of read data
		logic [15:0]       rd_s2;
	} emcs_st_type;

	emcs_st_type             s_r;                  // Registered state
	emcs_st_type             s_nxt;                // Next state
	logic [NUM_CS-1:0]       hit;                  // Decoder result
	logic [2:0]              sel;                  // Selected index as one-hot

	// ***************************************************************
	// Decoder
	// ***************************************************************
	emcs_decode u_dec (
		.cfg_i        (cfg_i),
		.zero_valid_i (s_r.zero_valid),
		.addr_i       (req_i.addr),
		.hit_o        (hit)
	);

	assign sel = hit;

	// Pick configuration of the hit select
	function automatic emcs_cfg_type pick(input logic [2:0] h, input emcs_cfg_type c [NUM_CS]);
		emcs_cfg_type r;
		r = c[0];
		if (h[1]) begin
			r = c[1];
		end else if (h[2]) begin
			r = c[2];
		end
		return r;
	endfunction : pick

	// ***************************************************************
	// Next state
	// ***************************************************************
	always_comb begin
		emcs_cfg_type c;
		logic         ext_ack;
		c       = pick(sel, cfg_i);
		ext_ack = ~s_r.ack_sync[1];                // Acknowledge pin, low active
		s_nxt   = s_r;
		s_nxt.ack_sync = {s_r.ack_sync[0], transfer_acknowledge_n_i}; // Two-flop sync
		s_nxt.rd_s1   = mem_rdata_i;
		s_nxt.rd_s2   = s_r.rd_s1;
		s_nxt.done    = 1'b0;
		s_nxt.err     = 1'b0;
		// Valid of select zero sticks until reset
		if (cfg_i[0].valid) begin
			s_nxt.zero_valid = 1'b1;
		end
		case (s_r.st)
			ST_IDLE: begin
				if (req_i.start) begin
					if (!s_r.zero_valid || hit != '0) begin
						if (c.port_width_setting == PW_32_BAD) begin
							s_nxt.err = 1'b1;      // Invalid port size
							s_nxt.done = 1'b1;
						end else begin
							s_nxt.st       = ST_SETUP;
							s_nxt.busy     = 1'b1;
							s_nxt.wide     = c.port_width_setting[1];
							s_nxt.auto_ack = s_r.zero_valid ? c.auto_acknowledge : 1'b1;
							s_nxt.cnt      = s_r.zero_valid ? c.wait_state_count : WAIT_RESET;
							s_nxt.wr       = req_i.write;
							s_nxt.bytea    = req_i.byte_access;
							s_nxt.odd      = req_i.addr[0];
							s_nxt.addr     = req_i.addr[ADDR_W-1:0];
							if (c.port_width_setting[1]) begin
								s_nxt.addr[0] = 1'b0;  // Word address from bit one
							end
							// A byte goes out on both lanes; the lane strobes pick one
							if (!c.port_width_setting[1] || req_i.byte_access) begin
								s_nxt.wdata = {req_i.wdata[7:0], req_i.wdata[7:0]};
							end else begin
								s_nxt.wdata = req_i.wdata;
							end
							s_nxt.wdoe     = req_i.write;
							s_nxt.cs_n     = ~hit;
							s_nxt.oe_n     = req_i.write;
							s_nxt.rw_n     = ~req_i.write;
							if (!c.port_width_setting[1] || req_i.byte_access) begin
								s_nxt.bls_n = (c.port_width_setting[1] && req_i.addr[0]) ?
									2'b10 : 2'b01;
							end else begin
								s_nxt.bls_n = 2'b00;
							end
						end
					end else begin
						s_nxt.err  = 1'b1;         // No select decodes
						s_nxt.done = 1'b1;
					end
				end
			end
			ST_SETUP: begin
				s_nxt.st = ST_WAIT;
			end
			ST_WAIT: begin
				// Count wait states or wait for external acknowledge
				if (ext_ack) begin
					s_nxt.st = ST_LATCH;            // External ends early
				end else if (s_r.auto_ack) begin
					if (s_r.cnt == '0) begin
						s_nxt.st = ST_LATCH;
					end else begin
						s_nxt.cnt = s_r.cnt - 1'b1; // One period per state
					end
				end
			end
			ST_LATCH: begin
				// Latch read data on this edge
				if (!s_r.wr) begin
					if (!s_r.wide) begin
						s_nxt.rdata = {8'h00, s_r.rd_s2[15:8]};
					end else if (s_r.bytea) begin
						s_nxt.rdata = {8'h00, s_r.odd ? s_r.rd_s2[7:0] : s_r.rd_s2[15:8]};
					end else begin
						s_nxt.rdata = s_r.rd_s2;
					end
				end
				s_nxt.st    = ST_IDLE;
				s_nxt.cs_n  = '1;
				s_nxt.oe_n  = 1'b1;
				s_nxt.rw_n  = 1'b1;
				s_nxt.bls_n = 2'b11;
				s_nxt.wdoe  = 1'b0;
				s_nxt.busy  = 1'b0;
				s_nxt.done  = 1'b1;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	// ***************************************************************
	// Registers
	// ***************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r       <= '0;
			s_r.st    <= ST_IDLE;
			s_r.cs_n  <= '1;
			s_r.oe_n  <= 1'b1;
			s_r.rw_n  <= 1'b1;
			s_r.bls_n <= 2'b11;
			s_r.ack_sync <= 2'b11;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flops
	assign mem_addr_o           = s_r.addr;
	assign mem_wdata_o          = s_r.wdata;
	assign mem_wdata_oe_o       = s_r.wdoe;
	assign cs_n_o               = s_r.cs_n;
	assign oe_n_o               = s_r.oe_n;
	assign rw_n_o               = s_r.rw_n;
	assign byte_lane_select_n_o = s_r.bls_n;
	assign busy_o               = s_r.busy;
	assign done_o               = s_r.done;
	assign error_o              = s_r.err;
	assign rdata_o              = s_r.rdata;

	// ***************************************************************
	// Checks
	// ***************************************************************
	chk_one_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
		$countones(~cs_n_o) <= 1) else $error("more than one strobe");
	chk_oe_read: assert property (@(posedge clk_i) disable iff (rst_i)
		!oe_n_o |-> (cs_n_o != '1) && rw_n_o) else $error("oe outside read");
	chk_wait_len: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == ST_WAIT && s_r.auto_ack && s_r.cnt == 4'h2 && s_r.ack_sync[1])
		|=> s_r.cnt == 4'h1) else $error("wait count slip");
	chk_word_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st != ST_IDLE && s_r.wide) |-> !mem_addr_o[0]) else $error("bit zero used");
	chk_cs12_dead: assert property (@(posedge clk_i) disable iff (rst_i)
		!s_r.zero_valid |-> cs_n_o[2:1] == 2'b11) else $error("early select");
	chk_ext_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == ST_WAIT && !s_r.ack_sync[1]) |=> s_r.st == ST_LATCH)
		else $error("ack ignored");
	chk_done_end: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == ST_LATCH) |=> done_o && cs_n_o == '1) else $error("no end");
	chk_byte_lane: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == ST_LATCH && !s_r.wr && s_r.bytea) |=> rdata_o[15:8] == 8'h00)
		else $error("lane leak");

endmodule : emcs_top

// ===== verif/emcs_mem_model.sv
`timescale 1ns/1ps
// Async memory model behind the chip selects
module emcs_mem_model
	import emcs_pkg::*;
(
	// Clock and strobes
	input  wire logic              clk_i,
	input  wire logic [NUM_CS-1:0] cs_n_i,
	input  wire logic              oe_n_i,
	input  wire logic              rw_n_i,
	input  wire logic [1:0]        lane_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [15:0]       wdata_i,
	// Acknowledge control
	input  wire logic              ack_en_i,
	input  wire logic [4:0]        ack_cyc_i,
	// Pins back to the block
	output logic [15:0]            rdata_o,
	output logic                   ack_n_o
);
	logic [15:0] mem [256];           // Word array
	logic [15:0] last_r = 16'h0;      // Last word driven
	logic [4:0]  cnt_r = 5'h0;        // Cycles selected
	wire  logic  sel = ~&cs_n_i;      // Any select low
	wire  logic [7:0] widx = addr_i[8:1];   // Word index from bit one
	// Lane writes; both lanes wired as a word memory
	always @(posedge clk_i) begin
		if (sel && !rw_n_i && !lane_n_i[1]) mem[widx][15:8] <= wdata_i[15:8];
		if (sel && !rw_n_i && !lane_n_i[0]) mem[widx][7:0] <= wdata_i[7:0];
		if (sel && !oe_n_i) last_r <= mem[widx];
		cnt_r <= sel ? cnt_r + 5'h1 : 5'h0;
	end
	// Released bus shows inverse, so stale data never passes
	assign rdata_o = (sel && !oe_n_i) ? mem[widx] : ~last_r;
	// Prompt or slow external acknowledge
	assign ack_n_o = !(ack_en_i && sel && cnt_r >= ack_cyc_i);
endmodule : emcs_mem_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import emcs_pkg::*;
;
	// ********
	// Signals
	// ********
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	emcs_cfg_type      cfg [NUM_CS];
	emcs_req_type      req;
	logic              ack_n, ack_en, oe_n, rw_n, wdoe, busy, done, err;
	logic [4:0]        ack_cyc;
	logic [15:0]       mrd, wd, rd, wd_s, rd_s;
	logic [ADDR_W-1:0] ma;
	logic [NUM_CS-1:0] cs_n, cs_s;
	logic [1:0]        ln, ln_s;
	logic              oe_s, rw_s, a0_s, err_s;   // Strobes sampled just after the take edge, err_s when done is seen
	logic              wdoe_s, busy_s;            // Sampled with the strobes
	int                n_errors = 0;
	int                checked = 0;
	int                cyc;                       // Edges from take to done

	always #20 clk_i = ~clk_i;

	emcs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .req_i(req),
		.transfer_acknowledge_n_i(ack_n), .mem_rdata_i(mrd), .mem_addr_o(ma),
		.mem_wdata_o(wd), .mem_wdata_oe_o(wdoe),
		.cs_n_o(cs_n), .oe_n_o(oe_n), .rw_n_o(rw_n), .byte_lane_select_n_o(ln),
		.busy_o(busy), .done_o(done), .error_o(err), .rdata_o(rd));
	emcs_mem_model i_mem (.clk_i(clk_i), .cs_n_i(cs_n), .oe_n_i(oe_n), .rw_n_i(rw_n),
		.lane_n_i(ln), .addr_i(ma), .wdata_i(wd), .ack_en_i(ack_en), .ack_cyc_i(ack_cyc),
		.rdata_o(mrd), .ack_n_o(ack_n));

	// ********
	// Helpers
	// ********
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		if (n_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	// One transfer; all sampling on rising edges
	task automatic xfer(input logic w, input logic [31:0] a, input logic b, input logic [15:0] d);
		req = '{start: 1'b1, write: w, addr: a, byte_access: b, wdata: d};
		@(posedge clk_i);
		#1 req.start = 1'b0;
		// Strobes, or the one-cycle error answer, stand from the take edge on
		{cs_s, oe_s, rw_s, ln_s, a0_s, wd_s} = {cs_n, oe_n, rw_n, ln, ma[0], wd};
		{wdoe_s, busy_s} = {wdoe, busy};
		cyc = 1;
		while (done !== 1'b1 && cyc < 60) begin
			@(posedge clk_i);
			#1 cyc++;
		end
		chk(done, 1'b1);
		{err_s, rd_s} = {err, rd};
	endtask : xfer

	// Fields first, valid a cycle later
	task automatic setup_cs(input int i, input logic [15:0] b, m, input logic [3:0] wc,
		input logic [1:0] pw);
		cfg[i] = '{b, m, wc, 1'b1, pw, 1'b0};
		@(posedge clk_i);
		#1 cfg[i].valid = 1'b1;
	endtask : setup_cs

	// ********
	// Scenarios
	// ********
	// Select one valid too early: boot select still catches it
	task automatic t_boot();
		setup_cs(1, 16'h0040, 16'h0003, 4'h2, 2'h2);
		xfer(1'b0, 32'h0040_0000, 1'b0, 16'h0);
		chk({cs_s, oe_s}, {3'h6, 1'b0});
		chk(cyc, 32'h13);
	endtask : t_boot

	// Word write and read back on the word port
	task automatic t_word();
		xfer(1'b1, 32'h0040_0102, 1'b0, 16'hA55A);
		chk({cs_s, oe_s, rw_s, ln_s, a0_s}, {3'h5, 1'b1, 1'b0, 2'h0, 1'b0});
		chk(cyc, 32'h6);
		chk({wdoe_s, busy_s}, 2'h3);
		xfer(1'b0, 32'h0040_0102, 1'b0, 16'h0);
		chk({cs_s, oe_s, rd_s}, {3'h5, 1'b0, 16'hA55A});
		chk({wdoe_s, busy_s}, 2'h1);
	endtask : t_word

	// Wait counts 0 to 3 each add exactly one cycle
	task automatic t_wait();
		for (int wcount = 0; wcount < 4; wcount++) begin
			cfg[1].wait_state_count = wcount[3:0];
			xfer(1'b0, 32'h0040_0102, 1'b0, 16'h0);
			chk(cyc, wcount + 4);
		end
		cfg[1].wait_state_count = 4'h2;
	endtask : t_wait

	// Byte lanes on the word port
	task automatic t_byte();
		xfer(1'b1, 32'h0040_0103, 1'b1, 16'h003C);
		chk({ln_s, a0_s}, {2'h2, 1'b0});
		xfer(1'b0, 32'h0040_0103, 1'b1, 16'h0);
		chk(rd_s[7:0], 8'h3C);
		xfer(1'b0, 32'h0040_0102, 1'b1, 16'h0);
		chk(rd_s, 16'h00A5);
		xfer(1'b1, 32'h0040_0102, 1'b1, 16'h0077);
		chk({ln_s, wd_s[15:8]}, {2'h1, 8'h77});
		xfer(1'b0, 32'h0040_0102, 1'b0, 16'h0);
		chk(rd_s, 16'h773C);
	endtask : t_byte

	// Window edges of both masks
	task automatic t_window();
		xfer(1'b0, 32'h0043_FFFE, 1'b0, 16'h0);
		chk({cs_s, err_s}, {3'h5, 1'b0});
		xfer(1'b0, 32'h0087_FFFE, 1'b0, 16'h0);
		chk({cs_s, err_s}, {3'h3, 1'b0});
		xfer(1'b0, 32'h0044_0000, 1'b0, 16'h0);
		chk({cs_s, err_s, cyc[3:0]}, {3'h7, 1'b1, 4'h1});
		xfer(1'b0, 32'h0088_0000, 1'b0, 16'h0);
		chk({cs_s, err_s}, {3'h7, 1'b1});
	endtask : t_window

	// Byte port on the upper lane, then the bad encoding
	task automatic t_narrow();
		xfer(1'b1, 32'h0000_0011, 1'b1, 16'h005E);
		chk({ln_s, wd_s[15:8]}, {2'h1, 8'h5E});
		xfer(1'b0, 32'h0000_0011, 1'b1, 16'h0);
		chk(rd_s[7:0], 8'h5E);
		cfg[2].port_width_setting = PW_32_BAD;
		xfer(1'b0, 32'h0080_0000, 1'b0, 16'h0);
		chk({cs_s, err_s}, {3'h7, 1'b1});
		cfg[2].port_width_setting = 2'h3;
	endtask : t_narrow

	// Slow external ack alone, then an early one over auto ack
	task automatic t_ack();
		cfg[2].auto_acknowledge = 1'b0;
		{ack_en, ack_cyc} = {1'b1, 5'hA};
		xfer(1'b0, 32'h0080_0000, 1'b0, 16'h0);
		chk(cyc > 10 && cyc < 20, 1'b1);
		{cfg[2].auto_acknowledge, cfg[2].wait_state_count, ack_cyc} = {1'b1, 4'h8, 5'h1};
		xfer(1'b0, 32'h0080_0000, 1'b0, 16'h0);
		chk(cyc < 12, 1'b1);
		ack_en = 1'b0;
	endtask : t_ack

	// ********
	// Main sequence
	// ********
	initial begin
		cfg = '{default: '0};
		cfg[0].port_width_setting = 2'h2;   // Boot select answers as a word port
		req = '0;
		{ack_en, ack_cyc} = '0;
		repeat (6) @(posedge clk_i);
		#1 rst_i = 1'b0;
		t_boot();
		setup_cs(0, 16'h0000, 16'h0000, 4'h1, PW_8);
		setup_cs(2, 16'h0080, 16'h0007, 4'h0, 2'h3);
		t_word();
		t_wait();
		t_byte();
		t_window();
		t_narrow();
		t_ack();
		wrap_up();
	end

	// Watchdog, far beyond the roughly 140 cycles needed
	initial begin
		#(40 * 4000);
		n_errors++;
		wrap_up();
	end
endmodule : tb_top
